// File: hdl/audio_ctrl_defs.svh
// Shared constants for the DAC serial format and mute control block
`ifndef AUDIO_CTRL_DEFS_SVH
`define AUDIO_CTRL_DEFS_SVH

// Control word layout: address in the top bits, data below
`define CTL_WORD_MSB 15
`define CTL_ADDR_MSB 15
`define CTL_ADDR_LSB 9
`define CTL_DATA_MSB 8

// Register addresses
`define REG_DAC_CHANNEL_CONTROL 7'h02
`define REG_DAC_INTERFACE_FORMAT 7'h03
`define REG_DAC_ZERO_MUTE_CONTROL 7'h09
`define REG_ADC_MUTE_CONTROL 7'h0C

// Reset values
`define RST_DAC_CHANNEL_CONTROL 9'h120
`define RST_DAC_INTERFACE_FORMAT 9'h000
`define RST_DAC_ZERO_MUTE_CONTROL 9'h000
`define RST_ADC_MUTE_CONTROL 9'h000

// dac_channel_control fields
`define F_GLOBAL_MUTE 0
`define F_POWERDOWN_ALL 2
`define F_ROUTE_LEFT_MSB 6
`define F_ROUTE_LEFT_LSB 5
`define F_ROUTE_RIGHT_MSB 8
`define F_ROUTE_RIGHT_LSB 7

// dac_interface_format fields
`define F_FORMAT_MSB 1
`define F_FORMAT_LSB 0
`define F_FRAME_POLARITY 2
`define F_BITCLK_INVERT 3
`define F_WORD_LEN_MSB 5
`define F_WORD_LEN_LSB 4
`define F_PHASE_MSB 8
`define F_PHASE_LSB 6

// dac_zero_mute_control fields
`define F_ZERO_CROSS_DISABLE 0
`define F_ZERO_FLAG_MSB 2
`define F_ZERO_FLAG_LSB 1
`define F_CHAN_MUTE_MSB 5
`define F_CHAN_MUTE_LSB 3

// adc_mute_control fields
`define F_ADC_RIGHT_MUTE 0
`define F_ADC_LEFT_MUTE 1
`define F_ADC_BOTH_MUTE 2

// Word length codes and their bit counts
`define WL_CODE_16 2'h0
`define WL_CODE_20 2'h1
`define WL_CODE_24 2'h2
`define WL_CODE_32 2'h3
`define WL_BITS_16 7'h10
`define WL_BITS_20 7'h14
`define WL_BITS_24 7'h18
`define WL_BITS_32 7'h20

// Zero flag routing codes
`define ZFS_ALL 2'h0
`define ZFS_CH1 2'h1
`define ZFS_CH2 2'h2

// Frame timing
`define BIT_CNT_MAX 7'h7F
`define DELAY_ONE_BIT 7'h01
`define DELAY_NONE 7'h00

// Soft mute ramp and zero detect
`define GAIN_FULL 9'h100
`define GAIN_STEP 9'h001
`define ZERO_RUN_FRAMES 1024
`define SAMPLE_MOST_NEG 24'h800000
`define SAMPLE_MOST_POS 24'h7FFFFF

`endif

// File: hdl/audio_ctrl_pkg.sv
// Types and shared helpers for the DAC serial format and mute control block
`include "audio_ctrl_defs.svh"
package audio_ctrl_pkg;

   // Serial framing modes in field order
   typedef enum logic [1:0] {FMT_RIGHT_JUST, FMT_LEFT_JUST, FMT_I2S, FMT_DSP} dac_format_t;

   // Sample presented to the filters
   typedef logic [23:0] sample_t;

   // Bits per word for a length code
   function automatic logic [6:0] word_bits(input logic [1:0] code);
      case (code)
         `WL_CODE_16: word_bits = `WL_BITS_16;
         `WL_CODE_20: word_bits = `WL_BITS_20;
         `WL_CODE_24: word_bits = `WL_BITS_24;
         default: word_bits = `WL_BITS_32;
      endcase
   endfunction : word_bits

endpackage : audio_ctrl_pkg

// File: hdl/soft_mute_ramp.sv
// Gain ramp that fades one stereo channel in and out
`timescale 1ns/100ps
`include "audio_ctrl_defs.svh"
module soft_mute_ramp
   import audio_ctrl_pkg::*;
(
   input wire logic i_clk, // System clock
   input wire logic i_rst_b, // Async reset, active low
   input wire logic i_valid, // Sample strobe
   input wire logic i_frame_tick, // Once per stereo frame
   input wire logic i_mute, // Mute request level
   input wire logic [23:0] i_sample, // Signed input sample
   output logic [23:0] o_sample // Scaled sample, registered
);

   logic [8:0] gain; // Current gain, full scale at GAIN_FULL
   logic signed [33:0] product; // Sample times gain

   // Gain steps once per frame so the slope is rate independent
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         gain <= `GAIN_FULL;
      end
      else if (i_frame_tick)
      begin
         if (i_mute && gain != 9'h000)
         begin
            gain <= gain - `GAIN_STEP; // Fade down
         end
         else if (!i_mute && gain != `GAIN_FULL)
         begin
            gain <= gain + `GAIN_STEP; // Fade back up
         end
      end
   end

   // Gain never exceeds full, so the product fits in 32 bits
   assign product = $signed(i_sample) * $signed({1'b0, gain});

   // Output register
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_sample <= 24'h000000;
      end
      else if (i_valid)
      begin
         o_sample <= product[31:8]; // Two's complement scale
      end
   end

endmodule : soft_mute_ramp

// File: hdl/zero_run_detect.sv
// Counts consecutive all-zero stereo frames on one channel
`timescale 1ns/100ps
`include "audio_ctrl_defs.svh"
module zero_run_detect
#(
   parameter int RUN_FRAMES = `ZERO_RUN_FRAMES // Frames before flagging
)
(
   input wire logic i_clk, // System clock
   input wire logic i_rst_b, // Async reset, active low
   input wire logic i_valid, // Sample strobe
   input wire logic i_right, // Strobe carries the right word
   input wire logic i_zero, // Sample equals zero
   output logic o_zero // Run reached, registered
);

   localparam int CW = $clog2(RUN_FRAMES + 1);
   localparam logic [CW-1:0] RUN_LAST = CW'(RUN_FRAMES);

   logic left_zero; // Left word of this frame was zero
   logic [CW-1:0] run; // Saturating frame count

   // Left half held until its right partner
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         left_zero <= 1'b0;
      end
      else if (i_valid && !i_right)
      begin
         left_zero <= i_zero;
      end
   end

   // Any non-zero word restarts the run at the frame's right word strobe
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         run <= '0;
         o_zero <= 1'b0;
      end
      else if (i_valid && i_right)
      begin
         if (left_zero && i_zero)
         begin
            if (run != RUN_LAST)
            begin
               run <= run + 1'b1;
            end
            o_zero <= (run >= RUN_LAST - 1'b1); // Flag at the count
         end
         else
         begin
            run <= '0;
            o_zero <= 1'b0;
         end
      end
   end

endmodule : zero_run_detect

// File: hdl/dac_serial_format_and_mute_ctrl.sv
// DAC serial audio receiver with format, phase, zero flag and mute control
`timescale 1ns/100ps
`include "audio_ctrl_defs.svh"
module dac_serial_format_and_mute_ctrl
   import audio_ctrl_pkg::*;
#(
   parameter int ZERO_RUN = `ZERO_RUN_FRAMES // Zero frames before flag
)
(
   input wire logic i_clk, // 250 MHz system clock
   input wire logic i_rst_b, // Async reset, active low
   input wire logic i_control_clock, // Control port shift clock pin
   input wire logic i_control_data, // Control port data pin
   input wire logic i_control_latch, // Control port latch pin
   input wire logic i_dac_bit_clock, // Audio bit clock pin
   input wire logic i_dac_frame_clock, // Audio frame clock pin
   input wire logic [2:0] i_dac_serial_data_in, // Audio data pins, one per DAC
   input wire logic [7:0] i_volume_value, // New digital volume
   input wire logic i_volume_load, // Volume load strobe
   output logic [23:0] o_sample_data_1, // DAC1 filter input
   output logic [23:0] o_sample_data_2, // DAC2 filter input
   output logic [23:0] o_sample_data_3, // DAC3 filter input
   output logic o_sample_valid, // Filter input strobe
   output logic o_sample_is_right, // Strobe carries right words
   output logic o_zero_flag_pin, // Zero flag pin
   output logic o_adc_left_mute, // ADC left input mute
   output logic o_adc_right_mute, // ADC right input mute
   output logic [7:0] o_volume_applied, // Volume in effect
   output logic o_volume_pending // Volume waiting for zero cross
);

   // Pin synchronisers, first stage read only by the second
   logic [2:0] ctl_clk_s; // Control clock stages
   logic [1:0] ctl_dat_s; // Control data stages
   logic [2:0] ctl_lat_s; // Control latch stages
   logic [2:0] bclk_s; // Bit clock stages
   logic [1:0] lrc_s; // Frame clock stages
   logic [2:0] din_m; // Data first stage
   logic [2:0] din_q; // Data second stage

   // Control port state
   logic [`CTL_WORD_MSB:0] ctl_shift; // Incoming control word
   logic [8:0] reg_chan; // dac_channel_control
   logic [8:0] reg_fmt; // dac_interface_format
   logic [8:0] reg_zero; // dac_zero_mute_control
   logic [8:0] reg_adc; // adc_mute_control

   // Receiver state
   logic prev_frame; // Frame level at last sample edge
   logic [6:0] bit_cnt; // Bits since frame boundary
   logic [31:0] line_sh [0:2]; // Per-line shift registers
   sample_t raw [0:2]; // Justified words
   logic raw_valid; // Word strobe
   logic raw_right; // Word is right channel
   logic [2:0] chan_zero; // Zero runs per DAC
   logic [23:0] proc_out [0:2]; // After soft mute
   logic prev_sign; // Channel 1 sign history
   logic [7:0] vol_wait; // Held volume

   // Pin capture from outside the clock domain
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctl_clk_s <= 3'h0;
         ctl_dat_s <= 2'h0;
         ctl_lat_s <= 3'h0;
         bclk_s <= 3'h0;
         lrc_s <= 2'h0;
         din_m <= 3'h0;
         din_q <= 3'h0;
      end
      else
      begin
         ctl_clk_s <= {ctl_clk_s[1:0], i_control_clock};
         ctl_dat_s <= {ctl_dat_s[0], i_control_data};
         ctl_lat_s <= {ctl_lat_s[1:0], i_control_latch};
         bclk_s <= {bclk_s[1:0], i_dac_bit_clock};
         lrc_s <= {lrc_s[0], i_dac_frame_clock};
         din_m <= i_dac_serial_data_in;
         din_q <= din_m;
      end
   end

   // Edges between second and third stages
   logic ctl_clk_rise;
   logic ctl_lat_rise;
   assign ctl_clk_rise = ctl_clk_s[1] & ~ctl_clk_s[2];
   assign ctl_lat_rise = ctl_lat_s[1] & ~ctl_lat_s[2];

   // Control word shifter, MSB first
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctl_shift <= 16'h0000;
      end
      else if (ctl_clk_rise)
      begin
         ctl_shift <= {ctl_shift[`CTL_WORD_MSB-1:0], ctl_dat_s[1]};
      end
   end

   // Commit on latch; unknown addresses are dropped silently
   logic [6:0] ctl_addr;
   logic [8:0] ctl_data;
   assign ctl_addr = ctl_shift[`CTL_ADDR_MSB:`CTL_ADDR_LSB];
   assign ctl_data = ctl_shift[`CTL_DATA_MSB:0];

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         reg_chan <= `RST_DAC_CHANNEL_CONTROL;
         reg_fmt <= `RST_DAC_INTERFACE_FORMAT;
         reg_zero <= `RST_DAC_ZERO_MUTE_CONTROL;
         reg_adc <= `RST_ADC_MUTE_CONTROL;
      end
      else if (ctl_lat_rise)
      begin
         case (ctl_addr)
            `REG_DAC_CHANNEL_CONTROL: reg_chan <= ctl_data;
            `REG_DAC_INTERFACE_FORMAT: reg_fmt <= ctl_data;
            `REG_DAC_ZERO_MUTE_CONTROL: reg_zero <= ctl_data;
            `REG_ADC_MUTE_CONTROL: reg_adc <= ctl_data;
            default: ; // Other registers live elsewhere
         endcase
      end
   end

   // Field decode
   dac_format_t fmt;
   logic is_dsp;
   logic is_rj;
   logic frame_pol;
   logic [1:0] wl_code;
   logic [1:0] wl_eff;
   logic [6:0] wl_bits;
   assign fmt = dac_format_t'(reg_fmt[`F_FORMAT_MSB:`F_FORMAT_LSB]);
   assign is_dsp = (fmt == FMT_DSP);
   assign is_rj = (fmt == FMT_RIGHT_JUST);
   assign frame_pol = reg_fmt[`F_FRAME_POLARITY];
   assign wl_code = reg_fmt[`F_WORD_LEN_MSB:`F_WORD_LEN_LSB];
   // Right justified 32-bit falls back to 24
   assign wl_eff = (is_rj && wl_code == `WL_CODE_32) ? `WL_CODE_24 : wl_code;
   assign wl_bits = word_bits(wl_eff);

   // Sample edge: rising by default, falling when inverted
   logic samp;
   assign samp = reg_fmt[`F_BITCLK_INVERT] ? (bclk_s[2] & ~bclk_s[1])
                                           : (bclk_s[1] & ~bclk_s[2]);

   // Frame level; in DSP polarity picks the variant
   logic frame;
   assign frame = lrc_s[1] ^ (frame_pol & ~is_dsp);

   logic boundary; // Start of a new frame half or DSP frame
   logic [6:0] cnt_now; // Position of the bit being sampled
   logic [6:0] first_bit; // Delay from boundary to MSB
   assign boundary = is_dsp ? (frame & ~prev_frame) : (frame != prev_frame);
   // I2S and DSP variant A delay the MSB one bit
   assign first_bit = (fmt == FMT_I2S || (is_dsp && !frame_pol)) ? `DELAY_ONE_BIT
                                                                 : `DELAY_NONE;
   assign cnt_now = boundary ? 7'h00 :
                    (bit_cnt == `BIT_CNT_MAX) ? bit_cnt : bit_cnt + 7'h01;

   logic [6:0] end_left; // Last bit of first word
   logic [6:0] end_right; // Last bit of DSP second word
   logic win_left;
   logic win_right;
   assign end_left = 7'(first_bit + wl_bits - 7'h01);
   assign end_right = 7'(end_left + wl_bits);
   assign win_left = (cnt_now >= first_bit) && (cnt_now <= end_left);
   assign win_right = is_dsp && (cnt_now > end_left) && (cnt_now <= end_right);

   // Which word completes at this edge, and on which side
   logic emit;
   logic emit_right;
   logic shift_en;
   always_comb
   begin
      emit = 1'b0;
      emit_right = 1'b0;
      shift_en = 1'b0;
      case (fmt)
         FMT_RIGHT_JUST:
         begin
            // Word ends at the boundary, LSB last
            shift_en = 1'b1;
            emit = boundary;
            emit_right = ~prev_frame;
         end
         FMT_LEFT_JUST:
         begin
            shift_en = win_left;
            emit = (cnt_now == end_left);
            emit_right = ~frame;
         end
         FMT_I2S:
         begin
            // Bits past the word are ignored
            shift_en = win_left;
            emit = (cnt_now == end_left);
            emit_right = frame;
         end
         FMT_DSP:
         begin
            // Left then right back to back after the pulse
            shift_en = win_left | win_right;
            emit = (cnt_now == end_left) || (cnt_now == end_right);
            emit_right = (cnt_now == end_right);
         end
         default:
         begin
            shift_en = 1'b0;
         end
      endcase
   end

   // Fit a received word to the 24-bit filter input
   function automatic sample_t justify(input logic [31:0] w, input logic [1:0] code);
      case (code)
         `WL_CODE_16: justify = {w[15:0], 8'h00};
         `WL_CODE_20: justify = {w[19:0], 4'h0};
         `WL_CODE_24: justify = w[23:0];
         default: justify = w[31:8];
      endcase
   endfunction : justify

   // Frame tracking and bit position
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         prev_frame <= 1'b0;
         bit_cnt <= `BIT_CNT_MAX;
      end
      else if (samp)
      begin
         prev_frame <= frame;
         bit_cnt <= cnt_now;
      end
   end

   // Shifting and word capture for all three lines
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         for (int i = 0; i < 3; i++)
         begin
            line_sh[i] <= 32'h00000000;
            raw[i] <= 24'h000000;
         end
         raw_valid <= 1'b0;
         raw_right <= 1'b0;
      end
      else
      begin
         raw_valid <= samp & emit;
         for (int i = 0; i < 3; i++)
         begin
            if (samp && shift_en)
            begin
               line_sh[i] <= {line_sh[i][30:0], din_q[i]};
            end
            if (samp && emit)
            begin
               // Right justified word excludes the bit at the boundary
               raw[i] <= justify(is_rj ? line_sh[i] : {line_sh[i][30:0], din_q[i]}, wl_eff);
            end
         end
         if (samp && emit)
         begin
            raw_right <= emit_right;
         end
      end
   end

   // Negate without wrapping the most negative code
   function automatic sample_t invert_sample(input sample_t s);
      invert_sample = (s == `SAMPLE_MOST_NEG) ? `SAMPLE_MOST_POS : 24'(-s);
   endfunction : invert_sample

   // Abrupt mute: powerdown or a routing side set to zero
   logic hard_mute;
   assign hard_mute = reg_chan[`F_POWERDOWN_ALL] |
                      (raw_right ? (reg_chan[`F_ROUTE_RIGHT_MSB:`F_ROUTE_RIGHT_LSB] == 2'h0)
                                 : (reg_chan[`F_ROUTE_LEFT_MSB:`F_ROUTE_LEFT_LSB] == 2'h0));

   // Per-DAC phase, mute ramp and zero detection
   for (genvar g = 0; g < 3; g++)
   begin : g_chan
      sample_t pre; // Phase applied, hard mute applied
      logic soft_mute; // Ramp request
      assign pre = hard_mute ? 24'h000000 :
                   reg_fmt[`F_PHASE_LSB+g] ? invert_sample(raw[g]) : raw[g];
      assign soft_mute = reg_zero[`F_CHAN_MUTE_LSB+g] |
                         reg_chan[`F_GLOBAL_MUTE];

      soft_mute_ramp u_ramp (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .i_valid(raw_valid),
         .i_frame_tick(raw_valid & raw_right),
         .i_mute(soft_mute),
         .i_sample(pre),
         .o_sample(proc_out[g])
      );

      zero_run_detect #(.RUN_FRAMES(ZERO_RUN)) u_zero (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .i_valid(raw_valid),
         .i_right(raw_right),
         .i_zero(raw[g] == 24'h000000),
         .o_zero(chan_zero[g])
      );
   end

   assign o_sample_data_1 = proc_out[0];
   assign o_sample_data_2 = proc_out[1];
   assign o_sample_data_3 = proc_out[2];

   // Strobe registered from raw_valid, so it rises in the cycle the ramp register updates
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_sample_valid <= 1'b0;
         o_sample_is_right <= 1'b0;
      end
      else
      begin
         o_sample_valid <= raw_valid;
         if (raw_valid)
         begin
            o_sample_is_right <= raw_right;
         end
      end
   end

   // Zero flag routing
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_zero_flag_pin <= 1'b0;
      end
      else
      begin
         case (reg_zero[`F_ZERO_FLAG_MSB:`F_ZERO_FLAG_LSB])
            `ZFS_ALL: o_zero_flag_pin <= &chan_zero;
            `ZFS_CH1: o_zero_flag_pin <= chan_zero[0];
            `ZFS_CH2: o_zero_flag_pin <= chan_zero[1];
            default: o_zero_flag_pin <= chan_zero[2];
         endcase
      end
   end

   // ADC input mutes, the both bit overrides each side
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_adc_left_mute <= 1'b0;
         o_adc_right_mute <= 1'b0;
      end
      else
      begin
         o_adc_left_mute <= reg_adc[`F_ADC_LEFT_MUTE] | reg_adc[`F_ADC_BOTH_MUTE];
         o_adc_right_mute <= reg_adc[`F_ADC_RIGHT_MUTE] | reg_adc[`F_ADC_BOTH_MUTE];
      end
   end

   // Zero cross seen on DAC1 left: sign change or exact zero
   logic zero_cross;
   assign zero_cross = raw_valid && !raw_right &&
                       ((raw[0][23] != prev_sign) || (raw[0] == 24'h000000));

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         prev_sign <= 1'b0;
      end
      else if (raw_valid && !raw_right)
      begin
         prev_sign <= raw[0][23];
      end
   end

   // Volume update; a new load replaces the held one
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_volume_applied <= 8'h00;
         o_volume_pending <= 1'b0;
         vol_wait <= 8'h00;
      end
      else if (i_volume_load)
      begin
         if (reg_zero[`F_ZERO_CROSS_DISABLE])
         begin
            o_volume_applied <= i_volume_value; // Immediate
            o_volume_pending <= 1'b0;
         end
         else
         begin
            vol_wait <= i_volume_value; // Deferred
            o_volume_pending <= 1'b1;
         end
      end
      else if (o_volume_pending && (zero_cross || reg_zero[`F_ZERO_CROSS_DISABLE]))
      begin
         o_volume_applied <= vol_wait;
         o_volume_pending <= 1'b0;
      end
   end

endmodule : dac_serial_format_and_mute_ctrl

// File: test/dac_ctrl_assertions.sv
// Port checks for the DAC format and mute block
`timescale 1ns/100ps
module dac_ctrl_checker (
   input wire logic i_clk, // Clock
   input wire logic i_rst_b, // Reset, active low
   input wire logic i_control_latch, // Latch pin
   input wire logic i_dac_bit_clock, // Bit clock pin
   input wire logic [7:0] i_volume_value, // New volume
   input wire logic i_volume_load, // Volume strobe
   input wire logic [23:0] o_sample_data_1, // DAC1 word
   input wire logic o_sample_valid, // Word strobe
   input wire logic o_sample_is_right, // Right side
   input wire logic o_zero_flag_pin, // Zero flag
   input wire logic o_adc_left_mute, // ADC left mute
   input wire logic o_adc_right_mute, // ADC right mute
   input wire logic [7:0] o_volume_applied, // Volume used
   input wire logic o_volume_pending // Volume held
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   logic [4:0] bit_idle; // Cycles since bit clock moved
   logic [4:0] latch_age; // Cycles since latch rose
   // Saturating ages: outputs may only move soon after a cause
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         bit_idle <= 5'h1F;
         latch_age <= 5'h1F;
      end
      else
      begin
         bit_idle <= $changed(i_dac_bit_clock) ? 5'h00 : bit_idle + 5'(bit_idle != 5'h1F);
         latch_age <= $rose(i_control_latch) ? 5'h00 : latch_age + 5'(latch_age != 5'h1F);
      end
   end
   chk_valid_gap: assert property (o_sample_valid |=> !o_sample_valid [*8])
      else $error("strobe too soon");
   chk_data_stand: assert property (!o_sample_valid |-> $stable(o_sample_data_1))
      else $error("data moved");
   chk_side_stand: assert property (!o_sample_valid |-> $stable(o_sample_is_right))
      else $error("side moved");
   chk_valid_cause: assert property (o_sample_valid |-> bit_idle < 5'h10)
      else $error("strobe, idle clock");
   chk_flag_cause: assert property ($rose(o_zero_flag_pin) |->
      bit_idle < 5'h10 || latch_age < 5'h10) else $error("flag rose alone");
   chk_adc_cause: assert property ($changed({o_adc_left_mute, o_adc_right_mute}) |->
      latch_age < 5'h0C) else $error("ADC mute moved");
   chk_vol_change: assert property ($changed(o_volume_applied) |->
      $past(i_volume_load) || $fell(o_volume_pending)) else $error("volume moved");
   chk_vol_direct: assert property (i_volume_load ##1 !o_volume_pending |->
      o_volume_applied == $past(i_volume_value)) else $error("volume late");
endmodule : dac_ctrl_checker
bind dac_serial_format_and_mute_ctrl dac_ctrl_checker chk_i (.*);

// File: test/audio_source_model.sv
// Serial audio source for the DAC data pins
`timescale 1ns/100ps
module audio_source_model (
   output logic o_bclk, // Bit clock, still between frames
   output logic o_frame, // Frame clock
   output logic [2:0] o_data // DAC1..3, DAC2 gets inverted bits
);
   logic inv = 1'b0; // Change data on the falling edge
   initial
   begin
      o_bclk = 1'b0;
      o_frame = 1'b0;
      o_data = 3'h0;
   end
   // One 64-bit frame; spare bits toggle
   task automatic frame(input logic [1:0] fmt, input logic pol, input logic [23:0] l, r);
      int j;
      logic [23:0] w;
      logic b;
      o_bclk = inv;
      for (int i = 0; i < 64; i++)
      begin
         j = (fmt == 2'h3) ? i - int'(!pol) : i % 32 - (fmt ? int'(fmt == 2'h2) : 8);
         w = ((fmt == 2'h3) ? j < 24 : i < 32) ? l : r;
         if (fmt == 2'h3 && j >= 24)
            j = j - 24;
         b = (j >= 0 && j < 24) ? w[23 - j] : i[0];
         o_frame = (fmt == 2'h3) ? i == 0 : (i < 32) ^ (fmt == 2'h2) ^ pol;
         o_data = {b, !b, b}; // MSB first, two's complement
         #32 o_bclk = !inv; // Sampling edge mid-bit
         #32 o_bclk = inv;
      end
      o_data = ~o_data;
   endtask : frame
endmodule : audio_source_model

// File: test/tb.sv
// Bench for the DAC format and mute block
`timescale 1ns/100ps
module tb;
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_control_clock = 1'b0, i_control_data = 1'b0; // Pins
   logic i_control_latch = 1'b0, i_volume_load = 1'b0; // Strobes
   logic [7:0] i_volume_value = 8'h00; // Volume to load
   logic i_dac_bit_clock, i_dac_frame_clock; // From source
   logic [2:0] i_dac_serial_data_in; // From source
   logic [23:0] o_sample_data_1, o_sample_data_2, o_sample_data_3; // Words
   logic o_sample_valid, o_sample_is_right, o_zero_flag_pin; // Strobe, side, flag
   logic o_adc_left_mute, o_adc_right_mute, o_volume_pending; // Levels
   logic [7:0] o_volume_applied; // Volume used
   wire [1:0] adc = {o_adc_left_mute, o_adc_right_mute}; // ADC mutes
   logic [23:0] left_seen = 24'h000000; // Last left DAC1 word
   int err_count = 0, checks = 0; // Tallies
   dac_serial_format_and_mute_ctrl #(.ZERO_RUN(4)) dut (.*);
   audio_source_model src (.o_bclk(i_dac_bit_clock), .o_frame(i_dac_frame_clock),
      .o_data(i_dac_serial_data_in));
   always #2 i_clk = ~i_clk;
   // Keep the latest left word
   always @(posedge i_clk)
      if (o_sample_valid === 1'b1 && o_sample_is_right === 1'b0)
         left_seen <= o_sample_data_1;
   task automatic chk(input string name, input logic [23:0] exp, got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Control word MSB first, then latch
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      for (int i = 15; i >= 0; i--)
      begin
         i_control_data = (i > 8) ? a[i - 9] : d[i];
         #16 i_control_clock = 1'b1;
         #16 i_control_clock = 1'b0;
      end
      #16 i_control_latch = 1'b1;
      #16 i_control_latch = 1'b0;
      #32;
   endtask : wr
   // Two frames so the receiver is aligned
   task automatic play(input logic [1:0] fmt, input logic pol, input logic [23:0] l, r);
      repeat (2) src.frame(fmt, pol, l, r);
      #64;
   endtask : play
   task automatic load(input logic [7:0] v);
      @(negedge i_clk);
      i_volume_value = v;
      i_volume_load = 1'b1;
      @(negedge i_clk);
      i_volume_load = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask : load
   task automatic stop_test();
      $display("Checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Watchdog
   initial
   begin
      #250000;
      err_count++;
      stop_test();
   end
   initial
   begin
      repeat (2) @(negedge i_clk);
      i_rst_b = 1'b1;
      repeat (4) @(negedge i_clk);
      chk("adc_rst", 24'h0, 24'(adc));
      // Every format, both polarities, both bit clock senses
      for (int i = 0; i < 8; i++)
      begin
         src.inv = i[0] ^ i[2];
         wr(7'h03, {5'h02, i[0] ^ i[2], i[2], i[1:0]});
         play(i[1:0], i[2], 24'h3A5C01 + 24'(i), 24'hC1B2A3 - 24'(i));
         chk("left", 24'h3A5C01 + 24'(i), left_seen);
         chk("last", i[1:0] ? 24'hC1B2A3 - 24'(i) : 24'h3A5C01 + 24'(i), o_sample_data_1);
      end
      src.inv = 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         wr(7'h03, {3'h0, c[1:0], 4'h1});
         play(2'h1, 1'b0, 24'h9ABCDE, 24'h13579B);
         chk("width", 24'h13579B & ~(24'hFF >> (c * 4)), o_sample_data_1);
      end
      wr(7'h03, 9'h030);
      play(2'h0, 1'b0, 24'h9ABCDE, 24'h13579B);
      chk("rj32", 24'h9ABCDE, o_sample_data_1);
      wr(7'h03, 9'h0A1);
      play(2'h1, 1'b0, 24'h000000, 24'h2468AC);
      chk("phase2", 24'h2468AD, o_sample_data_2);
      chk("phase1", 24'h2468AC, o_sample_data_1);
      chk("phase3", 24'h2468AC, o_sample_data_3);
      wr(7'h09, 9'h008);
      play(2'h1, 1'b0, 24'h000000, 24'h2468AC);
      chk("open2", 24'h2468AD, o_sample_data_2);
      chk("soft1", 24'h244443, o_sample_data_1);
      wr(7'h02, 9'h124);
      play(2'h1, 1'b0, 24'h000000, 24'h2468AC);
      chk("pdown", 24'h0, o_sample_data_2);
      wr(7'h02, 9'h120);
      wr(7'h09, 9'h002);
      play(2'h1, 1'b0, 24'h0, 24'h0);
      src.frame(2'h1, 1'b0, 24'h0, 24'h0);
      #64;
      chk("zero3", 24'h0, 24'(o_zero_flag_pin));
      src.frame(2'h1, 1'b0, 24'h0, 24'h0);
      #64;
      for (int s = 0; s < 4; s++)
      begin
         wr(7'h09, {6'h00, s[1:0], 1'b0});
         chk("zflag", 24'(s[0]), 24'(o_zero_flag_pin));
      end
      wr(7'h09, 9'h001);
      load(8'h5A);
      chk("vol_now", 24'h5A, 24'(o_volume_applied));
      wr(7'h09, 9'h000);
      load(8'h33);
      chk("vol_wait", 24'h15A, 24'({o_volume_pending, o_volume_applied}));
      play(2'h1, 1'b0, 24'h0, 24'h0);
      chk("vol_zc", 24'h033, 24'({o_volume_pending, o_volume_applied}));
      for (int k = 0; k < 3; k++)
      begin
         wr(7'h0C, 9'(1 << k));
         chk("adc", 24'(k == 2 ? 3 : k + 1), 24'(adc));
      end
      wr(7'h0D, 9'h000);
      chk("adc_hold", 24'h3, 24'(adc));
      stop_test();
   end
endmodule : tb
